// ==== verilog/prw_pkg.sv ====
// Overview of operation
// - Reset delay starts on power-good, wake, timeout
// - Reset delay lasts nominally five milliseconds
// - Halt gates CPU clock, keeps timers alive
// - Halt exits on taken interrupt or timeout
// - Stop ends on timeout, reset, wake source
// - Top recovery bit flags warm wake
// - Polarity bit selects high or low wake
// - Delay bit inserts or skips reset delay
// - Source bits pick port wake line
// - Comparator-mode port3 lines cannot wake
// - Bypass bit removes divide-by-two
// - Lowest bit adds divide-by-sixteen prescaler
// - Watchdog one-shot resets at terminal count
// - Watchdog off at reset, enabled for good
// - Watchdog register writable first 64 cycles
// - Timeout bits select four periods
// - Halt-activity bit keeps watchdog counting
// - Stop-activity bit needs RC clock
// - Clock-source bit picks RC or crystal
// - Watchdog instruction changes zero, sign, overflow
// - Low supply forces global reset
package prw_pkg;
   // Register indices; one word each, so the byte address is four times the index
   localparam logic [7:0] PRW_STOP_RECOVERY_IDX  = 8'h0b;
   localparam logic [7:0] PRW_WATCHDOG_IDX       = 8'h0f;
   localparam logic [7:0] PRW_STOP_RECOVERY_ADDR = PRW_STOP_RECOVERY_IDX * 8'h04;
   localparam logic [7:0] PRW_WATCHDOG_ADDR      = PRW_WATCHDOG_IDX * 8'h04;
   localparam logic [7:0] PRW_STATUS_ADDR        = 8'h10;
   // Stop recovery field positions
   localparam int PRW_SR_DIV16  = 0;
   localparam int PRW_SR_NODIV2 = 1;
   localparam int PRW_SR_SRC_LO = 2;
   localparam int PRW_SR_DELAY  = 5;
   localparam int PRW_SR_POL    = 6;
   localparam int PRW_SR_WARM   = 7;
   // Watchdog field positions
   localparam int PRW_WD_HALT   = 2;
   localparam int PRW_WD_STOP   = 3;
   localparam int PRW_WD_XTAL   = 4;
   // Reset values
   localparam logic [7:0] PRW_SR_RESET = 8'h20;
   localparam logic [7:0] PRW_WD_RESET = 8'h0d;
   // Timing
   localparam int PRW_CLK_HZ        = 10_000_000;
   localparam int PRW_POR_DELAY_US  = 5000;
   localparam int PRW_POR_CYCLES    = PRW_POR_DELAY_US * (PRW_CLK_HZ / 1_000_000);
   localparam int PRW_WD_OPEN_CYC   = 64;
   localparam int PRW_RC_PER_MS     = 1000;
   localparam int PRW_RC_T0_MS      = 5;
   localparam int PRW_RC_T1_MS      = 15;
   localparam int PRW_RC_T2_MS      = 25;
   localparam int PRW_RC_T3_MS      = 100;
   localparam int PRW_XT_T0         = 256;
   localparam int PRW_XT_T1         = 512;
   localparam int PRW_XT_T2         = 1024;
   localparam int PRW_XT_T3         = 4096;
   // Opcodes decoded from the core
   localparam logic [7:0] PRW_OP_STOP = 8'h6f;
   localparam logic [7:0] PRW_OP_HALT = 8'h7f;
   // Power state
   typedef enum logic [1:0] {PRW_RUN, PRW_HALT, PRW_STOP, PRW_DELAY} prw_state_t;
   // Status flags to the core
   typedef struct packed {
      logic zero;
      logic sign;
      logic overflow;
   } prw_flags_t;
endpackage

// ==== verilog/prw_power_reset_watchdog.sv ====
`timescale 1ns/10ps
module prw_power_reset_watchdog #(
   parameter int PorCycles  = prw_pkg::PRW_POR_CYCLES,
   parameter int RcDivide   = 10,
   parameter int MsCycles   = 10000
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              clkEn,
   // Supply, oscillators
   input  wire logic              supplyGood,
   input  wire logic              rcTick,
   // Core instruction interface
   input  wire logic              opValid,
   input  wire logic [7:0]        opCode,
   input  wire logic              watchdogInstr,
   input  wire logic              instrRetired,
   input  wire logic              interruptTaken,
   output logic                   cpuClockEnable,
   output logic                   oscEnable,
   output logic                   timerClockEnable,
   output logic                   globalReset,
   output logic [15:0]            restartVector,
   output prw_pkg::prw_flags_t    wdFlags,
   // Wake lines
   input  wire logic [3:0]        port3In,
   input  wire logic [7:0]        port2In,
   input  wire logic [2:0]        port3Analog,
   // AXI4-Lite slave
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   import prw_pkg::*;

   // Elaboration check: the counters cannot serve empty spans
   if (PorCycles < 1 || RcDivide < 1 || MsCycles < 1) begin : gBadParam
      $error("bad parameter");
   end

   // Reset synchroniser
   logic rstMeta_q;
   logic rstSync_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end
   wire logic rstn = rstSync_q;

   // Registers and state
   logic [7:0]   srCfg_q;       // Stop recovery settings
   logic [7:0]   wdCfg_q;       // Watchdog settings
   prw_state_t   state_q;
   logic [31:0]  delayCnt_q;    // Reset delay counter
   logic [31:0]  wdCnt_q;       // Watchdog counter
   logic         wdOn_q;        // Watchdog enabled
   logic [6:0]   openCnt_q;     // Write window counter
   logic         started_q;     // First instruction seen
   logic         supplyOld_q;
   logic         wdFire;
   logic         wakeHit;
   logic [1:0]   prescale_q;    // Divider chain: [1] toggles, [0] enable pulse
   logic [3:0]   div16_q;

   // Supply low or the reset delay state holds the global reset
   assign globalReset = !supplyGood || (state_q == PRW_DELAY);

   // Wake source select, comparator lines excluded
   always_comb begin
      logic srcLevel;
      srcLevel = 1'b0;
      case (srCfg_q[PRW_SR_SRC_LO +: 3])
         3'd1: srcLevel = port3In[0];
         3'd2: srcLevel = port3In[1] && !port3Analog[0];
         3'd3: srcLevel = port3In[2] && !port3Analog[1];
         3'd4: srcLevel = port3In[3] && !port3Analog[2];
         3'd5: srcLevel = port2In[7];
         3'd6: srcLevel = ~|port2In[3:0];
         3'd7: srcLevel = ~|port2In;
         default: srcLevel = 1'b0;
      endcase
      // Analog line masked: never matches either polarity
      if (srCfg_q[PRW_SR_SRC_LO +: 3] == 3'd0 ||
          (srCfg_q[PRW_SR_SRC_LO +: 3] inside {3'd2, 3'd3, 3'd4} &&
           port3Analog[srCfg_q[PRW_SR_SRC_LO +: 2] - 2'd2 + 2'd1 - 2'd1]))
         wakeHit = 1'b0;
      else
         wakeHit = (srcLevel == srCfg_q[PRW_SR_POL]);
   end

   // Watchdog terminal count by tap
   logic [31:0] wdLimit;
   always_comb begin
      case (wdCfg_q[1:0])
         2'd0: wdLimit = wdCfg_q[PRW_WD_XTAL] ? 32'(PRW_XT_T0) : 32'(PRW_RC_T0_MS * MsCycles);
         2'd1: wdLimit = wdCfg_q[PRW_WD_XTAL] ? 32'(PRW_XT_T1) : 32'(PRW_RC_T1_MS * MsCycles);
         2'd2: wdLimit = wdCfg_q[PRW_WD_XTAL] ? 32'(PRW_XT_T2) : 32'(PRW_RC_T2_MS * MsCycles);
         default: wdLimit = wdCfg_q[PRW_WD_XTAL] ? 32'(PRW_XT_T3) : 32'(PRW_RC_T3_MS * MsCycles);
      endcase
   end

   // Counting allowed by mode; stop needs the RC source
   logic wdTick;
   logic wdRun;
   // Crystal taps count processor clock periods, not raw clocks
   assign wdTick = wdCfg_q[PRW_WD_XTAL] ? (state_q != PRW_STOP && prescale_q[0]) : rcTick;
   always_comb begin
      case (state_q)
         PRW_HALT: wdRun = wdCfg_q[PRW_WD_HALT];
         PRW_STOP: wdRun = wdCfg_q[PRW_WD_STOP];
         PRW_RUN:  wdRun = 1'b1;
         default:  wdRun = 1'b0;
      endcase
   end
   assign wdFire = wdOn_q && wdRun && wdTick && (wdCnt_q >= wdLimit - 32'd1);

   // Power state machine
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= PRW_DELAY;
      end else if (clkEn) begin
         if (!supplyGood) begin
            state_q <= PRW_DELAY;
         end else begin
            case (state_q)
               PRW_RUN: begin
                  if (wdFire)
                     state_q <= PRW_DELAY;
                  else if (opValid && opCode == PRW_OP_STOP)
                     state_q <= PRW_STOP;
                  else if (opValid && opCode == PRW_OP_HALT)
                     state_q <= PRW_HALT;
               end
               PRW_HALT: begin
                  if (wdFire)
                     state_q <= PRW_DELAY;
                  else if (interruptTaken)
                     state_q <= PRW_RUN;
               end
               PRW_STOP: begin
                  if (wdFire)
                     state_q <= PRW_DELAY;
                  else if (wakeHit)
                     state_q <= srCfg_q[PRW_SR_DELAY] ? PRW_DELAY : PRW_RUN;
               end
               PRW_DELAY: begin
                  if (delayCnt_q >= 32'(PorCycles - 1))
                     state_q <= PRW_RUN;
               end
               default: state_q <= PRW_DELAY;
            endcase
         end
      end
   end

   // Reset delay counter
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         delayCnt_q <= 32'd0;
      else if (clkEn)
         delayCnt_q <= (state_q == PRW_DELAY && supplyGood) ? delayCnt_q + 32'd1 : 32'd0;
   end

   // Clocks out: CPU off in halt/stop, oscillator off in stop
   assign cpuClockEnable = (state_q == PRW_RUN) && prescale_q[0];
   assign oscEnable      = (state_q != PRW_STOP);
   assign timerClockEnable = (state_q != PRW_STOP) && prescale_q[0];
   assign restartVector  = 16'h000c;

   // Clock dividers: /2 unless bypassed, extra /16 optional
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div16_q    <= 4'h0;
         prescale_q <= 2'h0;
      end else if (clkEn) begin
         prescale_q[1] <= ~prescale_q[1];
         if (srCfg_q[PRW_SR_NODIV2] || prescale_q[1])
            div16_q <= div16_q + 4'h1;
         prescale_q[0] <= (srCfg_q[PRW_SR_NODIV2] || prescale_q[1]) &&
                          (!srCfg_q[PRW_SR_DIV16] || div16_q == 4'hf);
      end
   end

   // Watchdog counter and enable
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wdOn_q  <= 1'b0;
         wdCnt_q <= 32'd0;
      end else if (clkEn) begin
         if (!supplyGood) begin
            wdOn_q  <= 1'b0;
            wdCnt_q <= 32'd0;
         end else if (watchdogInstr && state_q == PRW_RUN) begin
            wdOn_q  <= 1'b1;
            wdCnt_q <= 32'd0;
         end else if (wdFire) begin
            wdCnt_q <= 32'd0;
         end else if (wdOn_q && wdRun && wdTick) begin
            wdCnt_q <= wdCnt_q + 32'd1;
         end
      end
   end

   // Flag effects of the watchdog instruction
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         wdFlags <= '0;
      else if (clkEn && watchdogInstr)
         wdFlags <= '{zero: 1'b0, sign: 1'b0, overflow: 1'b0};
   end

   // Write window after reset or recovery
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         started_q <= 1'b0;
         openCnt_q <= 7'd0;
      end else if (clkEn) begin
         // Halt must not reopen the window; only reset or stop recovery does
         if (state_q inside {PRW_STOP, PRW_DELAY}) begin
            started_q <= 1'b0;
            openCnt_q <= 7'd0;
         end else if (instrRetired && !started_q) begin
            started_q <= 1'b1;
         end else if (started_q && openCnt_q < 7'(PRW_WD_OPEN_CYC) && prescale_q[0]) begin
            openCnt_q <= openCnt_q + 7'd1;
         end
      end
   end
   logic wdOpen;
   assign wdOpen = (state_q == PRW_RUN) && (openCnt_q < 7'(PRW_WD_OPEN_CYC));

   // AXI write path: take address and data in either order
   logic awHeld_q;
   logic wHeld_q;
   logic [7:0]  awAddr_q;
   logic [7:0]  wData_q;
   logic        wLane_q;
   assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
   logic doWrite;
   assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         awHeld_q     <= 1'b0;
         wHeld_q      <= 1'b0;
         awAddr_q     <= 8'h00;
         wData_q      <= 8'h00;
         wLane_q      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (clkEn) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata[7:0];
            wLane_q <= s_axi_wstrb[0];
         end
         if (doWrite) begin
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_q == PRW_STOP_RECOVERY_ADDR || awAddr_q == PRW_WATCHDOG_ADDR ||
                             awAddr_q == PRW_STATUS_ADDR) ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Configuration registers; warm flag set by hardware
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         srCfg_q <= PRW_SR_RESET;
         wdCfg_q <= PRW_WD_RESET;
      end else if (clkEn) begin
         if (!supplyGood) begin
            srCfg_q <= PRW_SR_RESET;
            wdCfg_q <= PRW_WD_RESET;
         end else begin
            if (doWrite && wLane_q && awAddr_q == PRW_STOP_RECOVERY_ADDR)
               srCfg_q[6:0] <= wData_q[6:0];
            if (doWrite && wLane_q && awAddr_q == PRW_WATCHDOG_ADDR && wdOpen)
               wdCfg_q <= {3'b000, wData_q[4:0]};
            if (opValid && opCode == PRW_OP_STOP && state_q == PRW_RUN)
               srCfg_q[PRW_SR_WARM] <= 1'b1;
         end
      end
   end

   // AXI read path; watchdog register never readable
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'b00;
      end else if (clkEn) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
               PRW_STOP_RECOVERY_ADDR: s_axi_rdata <= {24'h0, srCfg_q[PRW_SR_WARM], 7'h00};
               PRW_WATCHDOG_ADDR:      s_axi_rdata <= 32'h0;
               PRW_STATUS_ADDR:        s_axi_rdata <= {28'h0, wdOn_q, wdOpen, state_q};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Assertions
   a_halt_cpu_off: assert property (@(posedge clock) disable iff (!rstn)
      state_q == PRW_HALT |-> !cpuClockEnable) else $error("cpu clock runs in halt");
   a_stop_osc_off: assert property (@(posedge clock) disable iff (!rstn)
      state_q == PRW_STOP |-> !oscEnable) else $error("oscillator runs in stop");
   a_low_supply_rst: assert property (@(posedge clock) disable iff (!rstn)
      clkEn && !supplyGood |=> globalReset && !wdOn_q) else $error("no reset on low supply");
   a_wd_lock: assert property (@(posedge clock) disable iff (!rstn)
      clkEn && !wdOpen && supplyGood |=> $stable(wdCfg_q)) else $error("watchdog register changed late");
   a_wd_sticky: assert property (@(posedge clock) disable iff (!rstn)
      wdOn_q && supplyGood |=> wdOn_q) else $error("watchdog disabled");
   a_halt_exit: assert property (@(posedge clock) disable iff (!rstn)
      clkEn && state_q == PRW_HALT && supplyGood && !wdFire && !interruptTaken |=> state_q == PRW_HALT)
      else $error("halt left without interrupt");
   a_fast_wake: assert property (@(posedge clock) disable iff (!rstn)
      clkEn && supplyGood && state_q == PRW_STOP && !wdFire && wakeHit && !srCfg_q[PRW_SR_DELAY]
      |=> state_q == PRW_RUN) else $error("fast wake failed");
   a_fire_reset: assert property (@(posedge clock) disable iff (!rstn)
      clkEn && supplyGood && wdFire |=> state_q == PRW_DELAY) else $error("timeout gave no reset");
endmodule

// ==== verif/prw_core_model.sv ====
`timescale 1ns/10ps
// Processor core stand-in: retires one instruction per processor clock
module prw_core_model (
   // Clock and status from the block
   input  wire logic       clock,
   input  wire logic       globalReset,
   input  wire logic       cpuClockEnable,
   // Instruction strobes
   output logic            opValid,
   output logic [7:0]      opCode,
   output logic            watchdogInstr,
   output logic            instrRetired,
   output logic            interruptTaken
);
   logic [8:0] pend[$];  // Queued {watchdog, opcode}
   logic       irqReq;   // Interrupt waiting to be taken
   logic [8:0] nxt;      // Entry being issued

   initial begin
      irqReq = 1'b0;
      {opValid, opCode, watchdogInstr, instrRetired, interruptTaken} = 12'h000;
   end

   // Sleep opcodes always trail a no-op so no instruction is cut in half
   task automatic sleepOp(input logic [7:0] op);
      pend.push_back({1'b0, 8'hff});
      pend.push_back({1'b0, op});
   endtask

   // Queue a watchdog instruction
   task automatic wdOp();
      pend.push_back(9'h100);
   endtask

   // Request an interrupt; taken even while halted
   task automatic irq();
      irqReq = 1'b1;
   endtask

   // Instructions issue only on processor clock enables, so a halted core only strobes interruptTaken
   always @(posedge clock) begin
      opValid        <= 1'b0;
      watchdogInstr  <= 1'b0;
      instrRetired   <= 1'b0;
      interruptTaken <= 1'b0;
      if (irqReq) begin
         interruptTaken <= 1'b1;
         irqReq = 1'b0;
      end else if (cpuClockEnable && !globalReset) begin
         instrRetired <= 1'b1;
         if (pend.size() > 0) begin
            nxt = pend.pop_front();
            watchdogInstr <= nxt[8];
            opValid       <= !nxt[8];
            opCode        <= nxt[7:0];
         end
      end
   end
endmodule

// ==== verif/power_reset_watchdog_control_test.sv ====
`timescale 1ns/10ps
// Register traffic, sleep modes, wake sources and watchdog
module power_reset_watchdog_control_test;
   import prw_pkg::*;
   localparam int PorCyc = 20;  // Shortened reset delay
   logic        clock, rst_n, supplyGood, rcTick, opValid, watchdogInstr, instrRetired, interruptTaken;
   logic [7:0]  opCode, port2In, awaddr, araddr;
   logic [3:0]  port3In;
   logic [2:0]  port3Analog;
   logic        cpuClockEnable, oscEnable, timerClockEnable, globalReset;
   logic [15:0] restartVector;
   prw_flags_t  wdFlags;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic        pol;
   int          n_mismatch, n_tests, cnt, src, rcCnt;
   logic [7:0]  divCfg[4] = '{8'h20, 8'h22, 8'h21, 8'h23};  // /2, bypass, /32, /16
   int          divExp[4] = '{80, 160, 5, 10};               // Pulses in 160 cycles

   prw_power_reset_watchdog #(.PorCycles(PorCyc), .RcDivide(10), .MsCycles(10)) uut (
      .clock(clock), .rst_n(rst_n), .clkEn(1'b1), .supplyGood(supplyGood), .rcTick(rcTick),
      .opValid(opValid), .opCode(opCode), .watchdogInstr(watchdogInstr), .instrRetired(instrRetired),
      .interruptTaken(interruptTaken), .cpuClockEnable(cpuClockEnable), .oscEnable(oscEnable),
      .timerClockEnable(timerClockEnable), .globalReset(globalReset), .restartVector(restartVector),
      .wdFlags(wdFlags), .port3In(port3In), .port2In(port2In), .port3Analog(port3Analog),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   prw_core_model core (
      .clock(clock), .globalReset(globalReset), .cpuClockEnable(cpuClockEnable), .opValid(opValid),
      .opCode(opCode), .watchdogInstr(watchdogInstr), .instrRetired(instrRetired),
      .interruptTaken(interruptTaken));

   // Free-running clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // RC oscillator tick, one in ten cycles
   initial rcCnt = 0;
   always @(posedge clock) begin
      rcCnt  <= (rcCnt + 1) % 10;
      rcTick <= (rcCnt == 0);
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Address and data offered together, each dropped once taken
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      bit aw, w;
      int k;
      aw = 0;
      w = 0;
      k = 0;
      @(posedge clock);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (!(aw && w) && k < 50) begin
         @(posedge clock);
         k++;
         aw |= awvalid & awready;
         w |= wvalid & wready;
         awvalid <= !aw;
         wvalid  <= !w;
      end
      bready <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (bvalid !== 1'b1 && k < 50);
      resp = bresp;
      bready <= 1'b0;
      if (k >= 50) n_mismatch++;
   endtask

   task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      int k;
      k = 0;
      @(posedge clock);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (arready !== 1'b1 && k < 50);
      arvalid <= 1'b0;
      do begin
         @(posedge clock);
         k++;
      end while (rvalid !== 1'b1 && k < 50);
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (k >= 50) n_mismatch++;
   endtask

   // Bounded wait for globalReset (0) or oscEnable (1) to reach a level
   task automatic waitFor(input int which, input logic lvl, input int lim, output int n);
      n = 0;
      while (n < lim && ((which == 0) ? globalReset : oscEnable) !== lvl) begin
         @(negedge clock);
         n++;
      end
   endtask

   // Counts timer (0) or processor (1) clock enables
   task automatic countPulses(input bit cpu, input int len, output int n);
      n = 0;
      repeat (len) begin
         @(negedge clock);
         n += cpu ? cpuClockEnable : timerClockEnable;
      end
   endtask

   // Puts the selected recovery source at a level
   task automatic setWake(input int s, input logic lvl);
      @(posedge clock);
      port3In <= (s >= 1 && s <= 4 && lvl) ? 4'(4'h1 << (s - 1)) : 4'h0;
      case (s)
         5: port2In <= lvl ? 8'h80 : 8'h00;
         6: port2In <= lvl ? 8'hf0 : 8'h0f;
         7: port2In <= lvl ? 8'h00 : 8'hff;
         default: port2In <= 8'h5a;
      endcase
   endtask

   initial begin
      {rst_n, port3In, port2In, port3Analog, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, n_mismatch, n_tests} = '0;
      supplyGood = 1'b1;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      waitFor(0, 1'b0, 60, cnt);
      check("por delay", 32'(cnt >= PorCyc && cnt <= PorCyc + 6), 32'h1);
      axiWrite(PRW_WATCHDOG_ADDR, 32'h10, r); // Crystal source, 256 periods, idle in halt and stop
      check("wd write resp", r, 2'b00);
      axiRead(PRW_STATUS_ADDR, d, r);
      check("status after por", d[3:0], 4'h4);
      axiRead(PRW_STOP_RECOVERY_ADDR, d, r);
      check("cold flag", d, 32'h0);
      axiRead(8'h20, d, r);
      check("unmapped read", r, 2'b10);
      axiWrite(8'h24, 32'h0, r);
      check("unmapped write", r, 2'b10);
      repeat (300) @(posedge clock);
      axiRead(PRW_STATUS_ADDR, d, r);
      check("window closed", d[2], 1'b0);
      foreach (divCfg[i]) begin
         axiWrite(PRW_STOP_RECOVERY_ADDR, {24'h0, divCfg[i]}, r);
         countPulses(1'b0, 160, cnt);
         check("timer rate", 32'(cnt >= divExp[i] - 1 && cnt <= divExp[i] + 1), 32'h1);
      end
      axiWrite(PRW_STOP_RECOVERY_ADDR, 32'h0, r);
      core.sleepOp(PRW_OP_HALT);
      repeat (20) @(posedge clock);
      axiRead(PRW_STATUS_ADDR, d, r);
      check("halt state", d[1:0], 2'(PRW_HALT));
      countPulses(1'b1, 40, cnt);
      check("cpu clock in halt", cnt, 0);
      countPulses(1'b0, 40, cnt);
      check("timer clock in halt", cnt, 20);
      check("osc in halt", oscEnable, 1'b1);
      core.irq();
      repeat (5) @(posedge clock);
      axiRead(PRW_STATUS_ADDR, d, r);
      check("halt exit", d[1:0], 2'(PRW_RUN));
      // Every wake source at high level, plus a low-level wake on line 0
      for (int i = 0; i < 8; i++) begin
         src = (i == 0) ? 1 : i;
         pol = (i != 0);
         setWake(src, !pol);
         axiWrite(PRW_STOP_RECOVERY_ADDR, {24'h0, 1'b0, pol, 1'b0, 3'(src), 2'b00}, r);
         core.sleepOp(PRW_OP_STOP);
         repeat (15) @(posedge clock);
         check("osc off in stop", oscEnable, 1'b0);
         check("restart vector", restartVector, 16'h000c);
         setWake(src, pol);
         waitFor(1, 1'b1, 30, cnt);
         check("wake by source", oscEnable, 1'b1);
         check("no wake delay", globalReset, 1'b0);
         repeat (10) @(posedge clock); // Source held ten more cycles, five processor clocks at divide-by-two
         setWake(src, !pol);
         axiRead(PRW_STOP_RECOVERY_ADDR, d, r);
         check("warm flag", d, 32'h80);
      end
      setWake(2, 1'b0);
      port3Analog <= 3'b001;
      axiWrite(PRW_STOP_RECOVERY_ADDR, 32'h48, r);
      core.sleepOp(PRW_OP_STOP);
      repeat (15) @(posedge clock);
      setWake(2, 1'b1);
      repeat (30) @(posedge clock);
      check("analog line ignored", oscEnable, 1'b0);
      port3Analog <= 3'b000;
      waitFor(1, 1'b1, 30, cnt);
      check("wake when digital", oscEnable, 1'b1);
      setWake(2, 1'b0);
      axiWrite(PRW_STOP_RECOVERY_ADDR, 32'h64, r);
      core.sleepOp(PRW_OP_STOP);
      repeat (15) @(posedge clock);
      setWake(1, 1'b1);
      waitFor(0, 1'b1, 10, cnt);
      check("delay after wake", globalReset, 1'b1);
      waitFor(0, 1'b0, 60, cnt);
      check("wake delay length", 32'(cnt >= PorCyc - 2 && cnt <= PorCyc + 4), 32'h1);
      setWake(1, 1'b0);
      axiWrite(PRW_WATCHDOG_ADDR, 32'h10, r);
      core.wdOp();
      repeat (300) @(posedge clock);
      axiRead(PRW_STATUS_ADDR, d, r);
      check("watchdog on", d[3], 1'b1);
      check("flags", wdFlags, 3'h0);
      axiWrite(PRW_WATCHDOG_ADDR, 32'h13, r); // Late write must leave the time-out alone
      core.wdOp();
      waitFor(0, 1'b1, 1200, cnt);
      check("time-out span", 32'(cnt >= 500 && cnt <= 530), 32'h1);
      waitFor(0, 1'b0, 60, cnt);
      @(posedge clock);
      supplyGood <= 1'b0;
      repeat (3) @(posedge clock);
      check("supply low reset", globalReset, 1'b1);
      supplyGood <= 1'b1;
      waitFor(0, 1'b0, 60, cnt);
      axiRead(PRW_STOP_RECOVERY_ADDR, d, r);
      check("cold after power loss", d, 32'h0);
      axiRead(PRW_STATUS_ADDR, d, r);
      check("watchdog off after power-on", d[3], 1'b0);
      summarize();
   end

   // Hang guard, well beyond the expected run
   initial begin
      #2_000_000;
      n_mismatch++;
      summarize();
   end
endmodule
